// File: verilog/csfpm_regs.svh
/*
  Constants for the clock switch, fail-safe and power mode controller.
  Assumes inclusion by the package and the design module only.
*/
`ifndef CSFPM_REGS_SVH
`define CSFPM_REGS_SVH
`define CSFPM_SETTLE_CYCLES   4'hA
`define CSFPM_CNT_ONE         4'h1
`define CSFPM_WAKE_CYCLES     2'h2
`define CSFPM_MODE_SLEEP      1'h0
`define CSFPM_MODE_IDLE       1'h1
`define CSFPM_SRC_W           3
`endif

// File: verilog/csfpm_pkg.sv
/*
  Types for the clock switch, fail-safe and power mode controller.
  Assumes the constants header sits beside it.
*/
`include "csfpm_regs.svh"
package csfpm_pkg;
  typedef enum logic [2:0] {
    SRC_FRC       = 3'h0,
    SRC_FRC_PLL   = 3'h1,
    SRC_PRI       = 3'h2,
    SRC_PRI_PLL   = 3'h3,
    SRC_SEC       = 3'h4,
    SRC_LOW_POWER_RC_SOURCE      = 3'h5,
    SRC_FRC_DIV16 = 3'h6,
    SRC_FRC_DIVN  = 3'h7
  } csfpm_src_type;

  typedef struct packed {
    logic fast_rc_source;
    logic pri;
    logic sec;
    logic low_power_rc_source;
    logic pll;
  } csfpm_osc_en_type;

  typedef struct packed {
    logic pri_ready;
    logic pll_lock;
    logic new_clk_tick;
    logic osc_fail;
  } csfpm_osc_stat_type;

  typedef enum {
    SW_IDLE,
    SW_START,
    SW_WAIT_READY,
    SW_SETTLE,
    SW_HANDOVER
  } csfpm_sw_state_type;

  typedef enum {
    PM_RUN,
    PM_SLEEP,
    PM_IDLE,
    PM_WAKE
  } csfpm_pm_state_type;
endpackage : csfpm_pkg

// File: verilog/csfpm_top.sv
/*
  Clock switch sequencer, fail-safe fallback and Sleep/Idle control.
  Assumes oscillator ready, lock, new-clock tick and failure inputs are
  already synchronous to i_clk; software bits arrive as single-cycle strobes.
*/
`timescale 1ns/10ps
`include "csfpm_regs.svh"
module csfpm_top
(
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  input  wire logic                        i_clock_switch_config_fuse,
  input  wire csfpm_pkg::csfpm_src_type    i_initial_source_fuse,
  input  wire logic [1:0]                  i_primary_submode_fuse,
  input  wire logic                        i_new_source_wr,
  input  wire csfpm_pkg::csfpm_src_type    i_new_source_select,
  input  wire logic                        i_switch_request_set,
  input  wire logic                        i_secondary_osc_enable,
  input  wire logic                        i_clock_fail_clear,
  input  wire logic                        i_watchdog_enable,
  input  wire csfpm_pkg::csfpm_osc_stat_type i_osc_stat,
  input  wire logic                        i_power_save_instruction,
  input  wire logic                        i_power_save_operand,
  input  wire logic                        i_wake_interrupt,
  input  wire logic                        i_watchdog_timeout,
  output logic                             o_switch_request_bit,
  output csfpm_pkg::csfpm_src_type         o_current_source_status,
  output csfpm_pkg::csfpm_src_type         o_new_source_select,
  output logic                             o_pll_lock_flag,
  output logic                             o_clock_fail_flag,
  output logic                             o_clock_fail_trap,
  output csfpm_pkg::csfpm_osc_en_type      o_osc_enable,
  output logic [1:0]                       o_primary_submode,
  output logic                             o_cpu_clk_en,
  output logic                             o_periph_clk_en,
  output logic                             o_watchdog_clear,
  output logic                             o_monitor_active
);
  import csfpm_pkg::*;

  csfpm_sw_state_type sw_state_reg;
  csfpm_pm_state_type pm_state_reg;
  csfpm_src_type      cur_reg;
  csfpm_src_type      new_reg;
  logic               req_reg;
  logic [3:0]         settle_reg;
  logic [1:0]         wake_reg;
  logic               sw_enabled;
  logic               monitor_on;
  logic               in_sleep;
  logic               target_ready;
  logic               fail_hit;
  logic               wake_event;
  csfpm_osc_en_type   osc_next;

  // Which physical oscillators a source code needs
  function automatic csfpm_osc_en_type src_needs(input csfpm_src_type s);
    csfpm_osc_en_type e;
    e = '0;
    case (s)
      SRC_FRC, SRC_FRC_DIV16, SRC_FRC_DIVN: e.fast_rc_source = 1'b1;
      SRC_FRC_PLL:
      begin
        e.fast_rc_source = 1'b1;
        e.pll = 1'b1;
      end
      SRC_PRI: e.pri = 1'b1;
      SRC_PRI_PLL:
      begin
        e.pri = 1'b1;
        e.pll = 1'b1;
      end
      SRC_SEC:  e.sec = 1'b1;
      SRC_LOW_POWER_RC_SOURCE: e.low_power_rc_source = 1'b1;
      default:  e = '0;
    endcase
    return e;
  endfunction : src_needs

  function automatic logic uses_pll(input csfpm_src_type s);
    return (s == SRC_FRC_PLL) || (s == SRC_PRI_PLL);
  endfunction : uses_pll

  assign sw_enabled = ~i_clock_switch_config_fuse;
  assign monitor_on = sw_enabled;
  assign in_sleep   = (pm_state_reg == PM_SLEEP);
  assign wake_event = i_wake_interrupt | i_watchdog_timeout;
  assign target_ready = (uses_pll(new_reg) ? i_osc_stat.pll_lock : 1'b1) &&
                        ((new_reg == SRC_PRI || new_reg == SRC_PRI_PLL) ? i_osc_stat.pri_ready : 1'b1);
  assign fail_hit   = monitor_on && !in_sleep && i_osc_stat.osc_fail &&
                      cur_reg != SRC_FRC && cur_reg != SRC_FRC_PLL;

  // New-source field, frozen while a switch runs
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      new_reg <= SRC_FRC;
    else if (!sw_enabled)
      new_reg <= i_initial_source_fuse;
    else if (i_new_source_wr && sw_state_reg == SW_IDLE && !req_reg)
      new_reg <= i_new_source_select;
  end

  // Switch sequencer
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      sw_state_reg <= SW_IDLE;
      req_reg      <= 1'b0;
      settle_reg   <= '0;
      cur_reg      <= SRC_FRC;
    end
    else if (!sw_enabled)
    begin
      sw_state_reg <= SW_IDLE;
      req_reg      <= 1'b0;
      cur_reg      <= i_initial_source_fuse;
    end
    else if (fail_hit)
    begin
      sw_state_reg <= SW_IDLE;
      req_reg      <= 1'b0;
      cur_reg      <= uses_pll(cur_reg) ? SRC_FRC_PLL : SRC_FRC;
    end
    else if (!in_sleep)
    begin
      case (sw_state_reg)
        SW_IDLE:
        begin
          if (i_switch_request_set && !in_sleep)
          begin
            req_reg      <= 1'b1;
            sw_state_reg <= SW_START;
          end
        end
        SW_START:
        begin
          if (cur_reg == new_reg)
          begin
            req_reg      <= 1'b0;
            sw_state_reg <= SW_IDLE;
          end
          else
            sw_state_reg <= SW_WAIT_READY;
        end
        SW_WAIT_READY:
        begin
          settle_reg <= '0;
          if (target_ready)
            sw_state_reg <= SW_SETTLE;
        end
        SW_SETTLE:
        begin
          if (i_osc_stat.new_clk_tick)
          begin
            settle_reg <= settle_reg + `CSFPM_CNT_ONE;
            if (settle_reg + `CSFPM_CNT_ONE == `CSFPM_SETTLE_CYCLES)
              sw_state_reg <= SW_HANDOVER;
          end
        end
        SW_HANDOVER:
        begin
          cur_reg      <= new_reg;
          req_reg      <= 1'b0;
          sw_state_reg <= SW_IDLE;
        end
        default: sw_state_reg <= SW_IDLE;
      endcase
    end
  end

  // Lock and fail flags; failure set wins over software clear
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_pll_lock_flag   <= 1'b0;
      o_clock_fail_flag <= 1'b0;
      o_clock_fail_trap <= 1'b0;
    end
    else
    begin
      o_clock_fail_trap <= fail_hit;
      if (sw_state_reg == SW_START && cur_reg != new_reg)
        o_pll_lock_flag <= 1'b0;
      else
        o_pll_lock_flag <= i_osc_stat.pll_lock;
      if (monitor_on && !in_sleep && i_osc_stat.osc_fail)
        o_clock_fail_flag <= 1'b1;
      else if (sw_state_reg == SW_START && cur_reg != new_reg)
        o_clock_fail_flag <= 1'b0;
      else if (i_clock_fail_clear)
        o_clock_fail_flag <= 1'b0;
    end
  end

  // Power-save modes
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pm_state_reg     <= PM_RUN;
      wake_reg         <= '0;
      o_watchdog_clear <= 1'b0;
    end
    else
    begin
      o_watchdog_clear <= 1'b0;
      case (pm_state_reg)
        PM_RUN:
        begin
          if (i_power_save_instruction)
          begin
            o_watchdog_clear <= i_watchdog_enable;
            pm_state_reg <= (i_power_save_operand == `CSFPM_MODE_SLEEP) ? PM_SLEEP : PM_IDLE;
          end
        end
        PM_SLEEP:
        begin
          if (wake_event)
            pm_state_reg <= PM_RUN;
        end
        PM_IDLE:
        begin
          wake_reg <= '0;
          if (wake_event)
            pm_state_reg <= PM_WAKE;
        end
        PM_WAKE:
        begin
          wake_reg <= wake_reg + 2'h1;
          if (wake_reg + 2'h1 == `CSFPM_WAKE_CYCLES)
            pm_state_reg <= PM_RUN;
        end
        default: pm_state_reg <= PM_RUN;
      endcase
    end
  end

  // Oscillator enables; previous source drops after handover
  always_comb
  begin
    osc_next = src_needs(cur_reg);
    if (sw_state_reg == SW_WAIT_READY || sw_state_reg == SW_SETTLE || sw_state_reg == SW_HANDOVER)
      osc_next = osc_next | src_needs(new_reg);
    if (i_secondary_osc_enable)
      osc_next.sec = 1'b1;
    if (in_sleep)
    begin
      osc_next.fast_rc_source = 1'b0;
      osc_next.pri = 1'b0;
      osc_next.pll = 1'b0;
      osc_next.low_power_rc_source = i_watchdog_enable;
    end
    else if (i_watchdog_enable || monitor_on)
      osc_next.low_power_rc_source = 1'b1;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_osc_enable            <= '0;
      o_switch_request_bit    <= 1'b0;
      o_current_source_status <= SRC_FRC;
      o_new_source_select     <= SRC_FRC;
      o_primary_submode       <= '0;
      o_cpu_clk_en            <= 1'b0;
      o_periph_clk_en         <= 1'b0;
      o_monitor_active        <= 1'b0;
    end
    else
    begin
      o_osc_enable            <= osc_next;
      o_switch_request_bit    <= req_reg & sw_enabled;
      o_current_source_status <= cur_reg;
      o_new_source_select     <= new_reg;
      o_primary_submode       <= i_primary_submode_fuse;
      o_cpu_clk_en            <= (pm_state_reg == PM_RUN);
      o_periph_clk_en         <= !in_sleep;
      o_monitor_active        <= monitor_on && !in_sleep;
    end
  end

  // Handover step followed by return to idle with the request dropped
  sequence s_settle_done;
    sw_state_reg == SW_HANDOVER ##1 (sw_state_reg == SW_IDLE && !req_reg);
  endsequence

  a_redundant_abort: assert property (@(posedge i_clk) disable iff (i_rst)
    (sw_state_reg == SW_START && cur_reg == new_reg && !in_sleep) |=> (!req_reg && sw_state_reg == SW_IDLE))
    else $error("redundant switch not aborted");

  a_disabled_req_zero: assert property (@(posedge i_clk) disable iff (i_rst)
    i_clock_switch_config_fuse |=> !req_reg ##1 !o_switch_request_bit)
    else $error("request set while switching disabled");

  a_disabled_status: assert property (@(posedge i_clk) disable iff (i_rst)
    i_clock_switch_config_fuse && $stable(i_initial_source_fuse) |=> cur_reg == $past(i_initial_source_fuse))
    else $error("status not from initial fuse");

  a_disabled_no_trap: assert property (@(posedge i_clk) disable iff (i_rst)
    i_clock_switch_config_fuse |=> (!o_clock_fail_trap && !o_monitor_active))
    else $error("failure monitor active while switching disabled");

  a_start_flags: assert property (@(posedge i_clk) disable iff (i_rst)
    (sw_state_reg == SW_START && cur_reg != new_reg && !i_osc_stat.osc_fail) |=>
      (!o_pll_lock_flag && !o_clock_fail_flag))
    else $error("flags not cleared on switch start");

  a_new_frozen: assert property (@(posedge i_clk) disable iff (i_rst)
    (req_reg && sw_enabled) |=> $stable(new_reg))
    else $error("new source changed during switch");

  a_handover_copy: assert property (@(posedge i_clk) disable iff (i_rst)
    (sw_state_reg == SW_HANDOVER && !i_osc_stat.osc_fail && sw_enabled && !in_sleep) |->
      s_settle_done ##0 (cur_reg == $past(new_reg)))
    else $error("handover did not copy source");

  a_settle_ten: assert property (@(posedge i_clk) disable iff (i_rst)
    (sw_state_reg == SW_HANDOVER) |-> (settle_reg == `CSFPM_SETTLE_CYCLES))
    else $error("handover before ten new-clock cycles");

  a_fail_fallback: assert property (@(posedge i_clk) disable iff (i_rst)
    (monitor_on && !in_sleep && i_osc_stat.osc_fail && cur_reg == SRC_PRI_PLL) |=>
      (cur_reg == SRC_FRC_PLL && o_clock_fail_trap))
    else $error("fallback not to fast RC with PLL");

  a_fail_plain: assert property (@(posedge i_clk) disable iff (i_rst)
    (monitor_on && !in_sleep && i_osc_stat.osc_fail && cur_reg == SRC_PRI) |=>
      (cur_reg == SRC_FRC && o_clock_fail_trap && o_clock_fail_flag))
    else $error("fallback not to fast RC");

  a_low_power_rc_source_monitor: assert property (@(posedge i_clk) disable iff (i_rst)
    (monitor_on && !in_sleep) |=> o_osc_enable.low_power_rc_source)
    else $error("low-power RC stopped while monitor on");

  a_sleep_gates: assert property (@(posedge i_clk) disable iff (i_rst)
    in_sleep |=> (!o_cpu_clk_en && !o_periph_clk_en && !o_osc_enable.fast_rc_source &&
      !o_osc_enable.pri && !o_monitor_active))
    else $error("sleep left clocks running");

  a_sleep_frozen: assert property (@(posedge i_clk) disable iff (i_rst)
    (in_sleep && sw_enabled) |=> ($stable(cur_reg) && $stable(sw_state_reg)))
    else $error("source changed during sleep");

  a_idle_periph: assert property (@(posedge i_clk) disable iff (i_rst)
    (pm_state_reg == PM_IDLE) |=> (o_periph_clk_en && !o_cpu_clk_en))
    else $error("idle clock gating wrong");

  a_idle_wake_delay: assert property (@(posedge i_clk) disable iff (i_rst)
    (pm_state_reg == PM_IDLE && wake_event) |=> !o_cpu_clk_en [*2] ##[1:2] o_cpu_clk_en)
    else $error("idle wake latency out of range");

  a_wdt_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    (pm_state_reg == PM_RUN && i_power_save_instruction && i_watchdog_enable) |=> o_watchdog_clear)
    else $error("watchdog not cleared on power save");
endmodule : csfpm_top

// File: testbench/tb.sv
/*
  Self-checking bench for the clock switch, fail-safe and power mode block.
  Assumes csfpm_pkg is compiled first; the bench drives every port itself.
*/
`timescale 1ns/10ps
module tb;
  import csfpm_pkg::*;
  logic               clk;
  logic               rst;
  logic               fuse_cs;
  csfpm_src_type      fuse_init;
  logic               new_wr;
  csfpm_src_type      new_sel;
  logic               req_set;
  logic               sec_en;
  logic               fail_clr;
  logic               wdt_en;
  csfpm_osc_stat_type stat;
  logic               ps_instr;
  logic               ps_op;
  logic               wake_int;
  logic               wdt_to;
  logic               req_bit;
  csfpm_src_type      cur;
  csfpm_src_type      new_src;
  logic               lock_flag;
  logic               fail_flag;
  logic               trap;
  csfpm_osc_en_type   osc;
  logic [1:0]         psub;
  logic [1:0]         submode;
  logic               cpu;
  logic               per;
  logic               wdt_clr;
  logic               mon;
  int                 mismatches;
  int                 tests_run;
  int                 n;
  int                 trap_cnt;
  int                 clr_cnt;

  csfpm_top dut (.i_clk(clk), .i_rst(rst), .i_clock_switch_config_fuse(fuse_cs),
    .i_initial_source_fuse(fuse_init), .i_primary_submode_fuse(psub), .i_new_source_wr(new_wr),
    .i_new_source_select(new_sel), .i_switch_request_set(req_set), .i_secondary_osc_enable(sec_en),
    .i_clock_fail_clear(fail_clr), .i_watchdog_enable(wdt_en), .i_osc_stat(stat),
    .i_power_save_instruction(ps_instr), .i_power_save_operand(ps_op), .i_wake_interrupt(wake_int),
    .i_watchdog_timeout(wdt_to), .o_switch_request_bit(req_bit), .o_current_source_status(cur),
    .o_new_source_select(new_src), .o_pll_lock_flag(lock_flag), .o_clock_fail_flag(fail_flag),
    .o_clock_fail_trap(trap), .o_osc_enable(osc), .o_primary_submode(submode), .o_cpu_clk_en(cpu),
    .o_periph_clk_en(per), .o_watchdog_clear(wdt_clr), .o_monitor_active(mon));

  always #20 clk = ~clk;

  // Pulse counters for one-cycle outputs
  always @(posedge clk)
  begin
    if (trap === 1'b1)
      trap_cnt <= trap_cnt + 1;
    if (wdt_clr === 1'b1)
      clr_cnt <= clr_cnt + 1;
  end

  task automatic check(input string what, input logic [2:0] seen, input logic [2:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr_new(input csfpm_src_type s);
    @(posedge clk);
    new_sel <= s;
    new_wr  <= 1'b1;
    @(posedge clk);
    new_wr  <= 1'b0;
  endtask : wr_new

  // Source code first, then the request strobe
  task automatic pulse_req(input csfpm_src_type s);
    wr_new(s);
    req_set <= 1'b1;
    @(posedge clk);
    req_set <= 1'b0;
  endtask : pulse_req

  task automatic ticks(input int k);
    repeat (k)
    begin
      @(posedge clk);
      stat.new_clk_tick <= 1'b1;
      @(posedge clk);
      stat.new_clk_tick <= 1'b0;
    end
    #1;
  endtask : ticks

  task automatic wait_req(input logic v, input int lim);
    n = 0;
    while (req_bit !== v && n < lim)
    begin
      cyc(1);
      n++;
    end
    check("request bit", 3'(req_bit), 3'(v));
  endtask : wait_req

  task automatic do_switch(input csfpm_src_type s);
    pulse_req(s);
    wait_req(1'b1, 4);
    ticks(10);
    wait_req(1'b0, 6);
    check("current source", cur, s);
  endtask : do_switch

  task automatic do_reset(input logic f, input csfpm_src_type s);
    @(posedge clk);
    fuse_cs   <= f;
    fuse_init <= s;
    rst       <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    cyc(3);
  endtask : do_reset

  task automatic power_save(input logic op);
    @(posedge clk);
    ps_op    <= op;
    ps_instr <= 1'b1;
    @(posedge clk);
    ps_instr <= 1'b0;
    cyc(4);
  endtask : power_save

  task automatic pulse_fail();
    @(posedge clk);
    stat.osc_fail <= 1'b1;
    @(posedge clk);
    stat.osc_fail <= 1'b0;
    cyc(3);
  endtask : pulse_fail

  initial
  begin
    #(40 * 4000);
    mismatches++;
    $display("timeout waiting for the block");
    final_report();
  end

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    fuse_cs = 1'b1;
    fuse_init = SRC_FRC;
    new_wr = 1'b0;
    new_sel = SRC_FRC;
    req_set = 1'b0;
    sec_en = 1'b0;
    fail_clr = 1'b0;
    wdt_en = 1'b0;
    stat = '0;
    ps_instr = 1'b0;
    ps_op = 1'b0;
    wake_int = 1'b0;
    wdt_to = 1'b0;
    psub = 2'h2;
    mismatches = 0;
    tests_run = 0;
    trap_cnt = 0;
    clr_cnt = 0;
    do_reset(1'b1, SRC_PRI);
    check("current source", cur, SRC_PRI);
    check("monitor", 3'(mon), 3'h0);
    check("submode", 3'(submode), 3'h2);
    pulse_req(SRC_SEC);
    repeat (6)
    begin
      cyc(1);
      check("request bit", 3'(req_bit), 3'h0);
    end
    pulse_fail();
    check("current source", cur, SRC_PRI);
    check("fail flag", 3'(fail_flag), 3'h0);
    $display("test switching disabled done");
    @(posedge clk);
    psub <= 2'h1;
    do_reset(1'b0, SRC_FRC);
    pulse_req(SRC_FRC);
    cyc(2);
    wait_req(1'b0, 6);
    check("current source", cur, SRC_FRC);
    $display("test redundant switch done");
    pulse_req(SRC_PRI_PLL);
    wait_req(1'b1, 4);
    ticks(12);
    check("request bit", 3'(req_bit), 3'h1);
    check("current source", cur, SRC_FRC);
    check("pll enable", 3'(osc.pll), 3'h1);
    check("primary enable", 3'(osc.pri), 3'h1);
    wr_new(SRC_SEC);
    cyc(2);
    check("new source", new_src, SRC_PRI_PLL);
    @(posedge clk);
    stat.pri_ready <= 1'b1;
    stat.pll_lock <= 1'b1;
    ticks(9);
    check("request bit", 3'(req_bit), 3'h1);
    check("current source", cur, SRC_FRC);
    ticks(1);
    wait_req(1'b0, 6);
    check("current source", cur, SRC_PRI_PLL);
    check("lock flag", 3'(lock_flag), 3'h1);
    cyc(2);
    check("fast rc enable", 3'(osc.fast_rc_source), 3'h0);
    check("low power rc", 3'(osc.low_power_rc_source), 3'h1);
    check("submode", 3'(submode), 3'h1);
    $display("test switch sequence done");
    pulse_fail();
    check("current source", cur, SRC_FRC_PLL);
    check("fail flag", 3'(fail_flag), 3'h1);
    check("trap count", 3'(trap_cnt), 3'h1);
    pulse_req(SRC_FRC);
    cyc(1);
    check("lock flag", 3'(lock_flag), 3'h0);
    cyc(3);
    check("fail flag", 3'(fail_flag), 3'h0);
    ticks(10);
    wait_req(1'b0, 6);
    do_switch(SRC_PRI);
    pulse_fail();
    check("current source", cur, SRC_FRC);
    check("trap count", 3'(trap_cnt), 3'h2);
    @(posedge clk);
    fail_clr <= 1'b1;
    @(posedge clk);
    fail_clr <= 1'b0;
    cyc(2);
    check("fail flag", 3'(fail_flag), 3'h0);
    $display("test fail-safe done");
    @(posedge clk);
    sec_en <= 1'b1;
    do_switch(SRC_SEC);
    do_switch(SRC_PRI);
    cyc(2);
    check("secondary enable", 3'(osc.sec), 3'h1);
    check("submode", 3'(submode), 3'h1);
    @(posedge clk);
    wdt_en <= 1'b1;
    power_save(1'b0);
    check("cpu clock", 3'(cpu), 3'h0);
    check("periph clock", 3'(per), 3'h0);
    check("primary enable", 3'(osc.pri), 3'h0);
    check("monitor", 3'(mon), 3'h0);
    check("low power rc", 3'(osc.low_power_rc_source), 3'h1);
    check("watchdog clears", 3'(clr_cnt), 3'h1);
    @(posedge clk);
    wake_int <= 1'b1;
    @(posedge clk);
    wake_int <= 1'b0;
    cyc(4);
    check("cpu clock", 3'(cpu), 3'h1);
    check("current source", cur, SRC_PRI);
    $display("test sleep done");
    power_save(1'b1);
    check("cpu clock", 3'(cpu), 3'h0);
    check("periph clock", 3'(per), 3'h1);
    check("primary enable", 3'(osc.pri), 3'h1);
    check("low power rc", 3'(osc.low_power_rc_source), 3'h1);
    check("watchdog clears", 3'(clr_cnt), 3'h2);
    @(posedge clk);
    wdt_to <= 1'b1;
    @(posedge clk);
    wdt_to <= 1'b0;
    #1;
    n = 0;
    while (cpu !== 1'b1 && n < 10)
    begin
      cyc(1);
      n++;
    end
    check("idle wake delay", 3'(n >= 2 && n <= 4), 3'h1);
    $display("test idle done");
    final_report();
  end
endmodule : tb
